// *** rtl/data_flash_program_erase_seq.v ***
// Data-flash program-words and erase-sector command sequencer.
// Functional notes
// - Program code 0x11, slots block, address, data
// - Word count follows index at launch
// - Program index outside 010..101 is access error
// - Odd word address is access error
// - Invalid 18-bit global address is access error
// - Command not permitted in mode is error
// - Word group past block end is error
// - Protected target sets protection violation instead
// - Verify afterwards, report error and uncorrectable
// - Erase code 0x12 erases whole sector, verifies
// - Erase index other than 001 is error
// - Clear completion flag launches; set when done
// - Command interrupt when flag and enable set
// - Error interrupt from enabled fault flags
// - Array ECC faults set double or single flags
// - Keep running in wait; interrupt wakes
// - Finish active command before stop entry
// - Reset aborts a running command at once
// - Flag clear during init; buffer writes ignored
`timescale 1ns/1ps
`include "dflash_seq_consts.vh"
module data_flash_program_erase_seq (
   input  wire        core_clk_i,
   input  wire        resetn_i,
   // Command buffer and index writes from the CPU.
   input  wire        param_slot_index_wr_i,
   input  wire [2:0]  param_slot_index_i,
   input  wire        command_param_buffer_wr_i,
   input  wire [15:0] command_param_buffer_data_i,
   output wire [2:0]  param_slot_index_o,
   output wire [15:0] command_param_buffer_o,
   // Status writes: one-to-clear strobes.
   input  wire        cmd_complete_clr_i,
   input  wire        access_error_clr_i,
   input  wire        protect_violation_clr_i,
   input  wire        double_fault_clr_i,
   input  wire        single_fault_clr_i,
   // Configuration.
   input  wire        cmd_complete_irq_en_i,
   input  wire        double_fault_irq_en_i,
   input  wire        single_fault_irq_en_i,
   input  wire        cmd_permitted_i,
   input  wire        area_protected_i,
   // Array side.
   output reg         array_prog_o,
   output reg         array_erase_o,
   output reg  [15:0] array_addr_o,
   output reg  [15:0] array_wdata_o,
   input  wire        array_read_i,
   input  wire        ecc_single_i,
   input  wire        ecc_double_i,
   // Status.
   output reg         cmd_complete_flag_o,
   output reg         access_error_flag_o,
   output reg         protect_violation_flag_o,
   output reg         verify_error_flag_o,
   output reg         verify_uncorrectable_flag_o,
   output reg         double_fault_flag_o,
   output reg         single_fault_flag_o,
   output wire        cmd_irq_o,
   output wire        err_irq_o,
   // Stop-mode handshake.
   input  wire        stop_req_i,
   output wire        stop_ack_o
);
   localparam ST_INIT   = 3'h0;
   localparam ST_IDLE   = 3'h1;
   localparam ST_CHECK  = 3'h2;
   localparam ST_PROG   = 3'h3;
   localparam ST_ERASE  = 3'h4;
   localparam ST_VERIFY = 3'h5;
   localparam ST_DONE   = 3'h6;
   localparam ST_FETCH  = 3'h7;

   localparam [15:0] INIT_CNT   = `INIT_CYCLES;
   localparam [15:0] PROG_CNT   = `PROG_CYCLES;
   localparam [15:0] ERASE_CNT  = `ERASE_CYCLES;
   localparam [15:0] VERIFY_CNT = `VERIFY_CYCLES;

   reg  [2:0]  state_r;
   reg  [2:0]  state_nxt;
   reg  [15:0] timer_r;
   reg  [2:0]  index_r;
   reg  [2:0]  rd_idx_r;
   reg  [2:0]  launch_idx_r;
   reg  [2:0]  word_cnt_r;
   reg  [7:0]  cmd_r;
   reg  [15:0] addr_r;
   reg  [1:0]  blk_r;
   reg         ver_err_r;
   reg         ver_unc_r;
   wire [15:0] rd_data;
   wire        buf_wr_ok;
   wire        launch;
   reg         chk_acc;
   reg  [2:0]  n_words;
   reg  [16:0] last_word;

   // Writes are ignored until the completion flag is set.
   assign buf_wr_ok = cmd_complete_flag_o;
   assign launch    = cmd_complete_flag_o && cmd_complete_clr_i && (state_r == ST_IDLE);

   always @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         index_r <= 3'h0;
      end else if (buf_wr_ok && param_slot_index_wr_i) begin
         index_r <= param_slot_index_i;
      end
   end

   param_buffer param_buffer_inst (
      .core_clk_i (core_clk_i),
      .resetn_i   (resetn_i),
      .wr_en_i    (buf_wr_ok && command_param_buffer_wr_i),
      .wr_idx_i   (index_r),
      .wr_data_i  (command_param_buffer_data_i),
      .rd_idx_i   (rd_idx_r),
      .rd_data_o  (rd_data)
   );
   assign param_slot_index_o     = index_r;
   assign command_param_buffer_o = rd_data;

   // Word count for a program launch; slot 010 means one word.
   always @* begin
      n_words   = launch_idx_r - `IDX_DATA_FIRST + 3'h1;
      last_word = {1'b0, rd_data} + {13'h0, n_words, 1'b0} - 17'h2;
   end

   // True when the block select and the word address lie inside the data-flash window.
   function addr_in_window;
      input [1:0]  blk;
      input [15:0] addr;
      begin
         addr_in_window = (blk == `DF_BLOCK_SEL) &&
                          (addr >= `DF_BASE_ADDR) &&
                          (addr <= `DF_LAST_ADDR);
      end
   endfunction

   // Checks are only used in the check cycle, where the read port shows the address slot.
   always @* begin
      chk_acc = 1'b0;
      if (!cmd_permitted_i) begin
         chk_acc = 1'b1;
      end
      if (rd_data[0]) begin
         chk_acc = 1'b1;
      end
      if (!addr_in_window(blk_r, rd_data)) begin
         chk_acc = 1'b1;
      end
      if (cmd_r == `CMD_PROGRAM_WORDS) begin
         if (launch_idx_r < `IDX_DATA_FIRST || launch_idx_r > `IDX_DATA_LAST) begin
            chk_acc = 1'b1;
         end else if (last_word > {1'b0, `DF_LAST_ADDR}) begin
            chk_acc = 1'b1;
         end
      end else if (cmd_r == `CMD_ERASE_SECTOR) begin
         if (launch_idx_r != `IDX_ADDR) begin
            chk_acc = 1'b1;
         end
      end else begin
         chk_acc = 1'b1;
      end
   end

   always @* begin
      state_nxt = state_r;
      case (state_r)
         ST_INIT: begin
            if (timer_r == 16'h0000) begin
               state_nxt = ST_IDLE;
            end
         end
         ST_IDLE: begin
            if (launch) begin
               state_nxt = ST_FETCH;
            end
         end
         // The extra fetch cycle reads slot 0 through the single read port, so the
         // port can keep showing the selected slot to software while idle.
         ST_FETCH: begin
            state_nxt = ST_CHECK;
         end
         ST_CHECK: begin
            if (chk_acc || area_protected_i) begin
               state_nxt = ST_DONE;
            end else if (cmd_r == `CMD_ERASE_SECTOR) begin
               state_nxt = ST_ERASE;
            end else begin
               state_nxt = ST_PROG;
            end
         end
         ST_PROG: begin
            if (timer_r == 16'h0000 && word_cnt_r == 3'h0) begin
               state_nxt = ST_VERIFY;
            end
         end
         ST_ERASE: begin
            if (timer_r == 16'h0000) begin
               state_nxt = ST_VERIFY;
            end
         end
         ST_VERIFY: begin
            if (timer_r == 16'h0000) begin
               state_nxt = ST_DONE;
            end
         end
         ST_DONE: begin
            state_nxt = ST_IDLE;
         end
         default: begin
            state_nxt = ST_INIT;
         end
      endcase
   end

   // Any reset drops the running command; the array state is then undefined.
   always @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         state_r                     <= ST_INIT;
         timer_r                     <= INIT_CNT;
         rd_idx_r                    <= 3'h0;
         launch_idx_r                <= 3'h0;
         word_cnt_r                  <= 3'h0;
         cmd_r                       <= 8'h00;
         addr_r                      <= 16'h0000;
         blk_r                       <= 2'h0;
         ver_err_r                   <= 1'b0;
         ver_unc_r                   <= 1'b0;
         array_prog_o                <= 1'b0;
         array_erase_o               <= 1'b0;
         array_addr_o                <= 16'h0000;
         array_wdata_o               <= 16'h0000;
         cmd_complete_flag_o         <= 1'b0;
         access_error_flag_o         <= 1'b0;
         protect_violation_flag_o    <= 1'b0;
         verify_error_flag_o         <= 1'b0;
         verify_uncorrectable_flag_o <= 1'b0;
      end else begin
         state_r       <= state_nxt;
         array_prog_o  <= 1'b0;
         array_erase_o <= 1'b0;
         if (access_error_clr_i) begin
            access_error_flag_o <= 1'b0;
         end
         if (protect_violation_clr_i) begin
            protect_violation_flag_o <= 1'b0;
         end
         if (timer_r != 16'h0000) begin
            timer_r <= timer_r - 16'h0001;
         end
         case (state_r)
            ST_INIT: begin
               if (timer_r == 16'h0000) begin
                  cmd_complete_flag_o <= 1'b1;
               end
            end
            ST_IDLE: begin
               rd_idx_r <= index_r;
               if (launch) begin
                  cmd_complete_flag_o         <= 1'b0;
                  launch_idx_r                <= index_r;
                  rd_idx_r                    <= `IDX_CMD;
                  verify_error_flag_o         <= 1'b0;
                  verify_uncorrectable_flag_o <= 1'b0;
               end
            end
            ST_FETCH: begin
               cmd_r    <= rd_data[15:8];
               blk_r    <= rd_data[1:0];
               rd_idx_r <= `IDX_ADDR;
            end
            ST_CHECK: begin
               addr_r     <= rd_data;
               rd_idx_r   <= `IDX_DATA_FIRST;
               word_cnt_r <= n_words;
               ver_err_r  <= 1'b0;
               ver_unc_r  <= 1'b0;
            end
            ST_DONE: begin
               cmd_complete_flag_o <= 1'b1;
            end
            default: begin
            end
         endcase
         if (state_r == ST_CHECK && state_nxt == ST_DONE) begin
            if (chk_acc) begin
               access_error_flag_o <= 1'b1;
            end else begin
               protect_violation_flag_o <= 1'b1;
            end
         end
         // Each word goes out once the timer of the previous one has run out.
         if (state_r == ST_PROG && timer_r == 16'h0000 && word_cnt_r != 3'h0) begin
            timer_r       <= PROG_CNT;
            word_cnt_r    <= word_cnt_r - 3'h1;
            rd_idx_r      <= rd_idx_r + 3'h1;
            addr_r        <= addr_r + 16'h0002;
            array_prog_o  <= 1'b1;
            array_addr_o  <= addr_r;
            array_wdata_o <= rd_data;
         end
         if (state_nxt == ST_ERASE && state_r != ST_ERASE) begin
            timer_r       <= ERASE_CNT;
            array_erase_o <= 1'b1;
            array_addr_o  <= {rd_data[15:`SECTOR_ADDR_BITS], {`SECTOR_ADDR_BITS{1'b0}}};
         end
         if (state_nxt == ST_VERIFY && state_r != ST_VERIFY) begin
            timer_r <= VERIFY_CNT;
         end
         if (state_r == ST_VERIFY && array_read_i) begin
            if (ecc_single_i || ecc_double_i) begin
               ver_err_r <= 1'b1;
            end
            if (ecc_double_i) begin
               ver_unc_r <= 1'b1;
            end
         end
         if (state_r == ST_VERIFY && timer_r == 16'h0000) begin
            verify_error_flag_o         <= ver_err_r ||
                                           (array_read_i && (ecc_single_i || ecc_double_i));
            verify_uncorrectable_flag_o <= ver_unc_r || (array_read_i && ecc_double_i);
         end
      end
   end

   // Fault flags: a new fault wins over a clear in the same cycle.
   always @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         double_fault_flag_o <= 1'b0;
         single_fault_flag_o <= 1'b0;
      end else begin
         if (array_read_i && ecc_double_i) begin
            double_fault_flag_o <= 1'b1;
         end else if (double_fault_clr_i) begin
            double_fault_flag_o <= 1'b0;
         end
         if (array_read_i && ecc_single_i && !ecc_double_i) begin
            single_fault_flag_o <= 1'b1;
         end else if (single_fault_clr_i) begin
            single_fault_flag_o <= 1'b0;
         end
      end
   end

   // No wait input exists: the sequencer runs regardless and the level wakes the CPU.
   assign cmd_irq_o  = cmd_complete_flag_o && cmd_complete_irq_en_i;
   assign err_irq_o  = (double_fault_flag_o && double_fault_irq_en_i) ||
                       (single_fault_flag_o && single_fault_irq_en_i);
   assign stop_ack_o = stop_req_i && cmd_complete_flag_o;
endmodule // data_flash_program_erase_seq

// *** rtl/dflash_seq_consts.vh ***
// Constants for the data-flash program and erase sequencer.
`ifndef DFLASH_SEQ_CONSTS_VH
`define DFLASH_SEQ_CONSTS_VH
`define CMD_PROGRAM_WORDS  8'h11
`define CMD_ERASE_SECTOR   8'h12
`define IDX_CMD            3'h0
`define IDX_ADDR           3'h1
`define IDX_DATA_FIRST     3'h2
`define IDX_DATA_LAST      3'h5
`define DF_BLOCK_SEL       2'h0
`define DF_BASE_ADDR       16'h4000
`define DF_LAST_ADDR       16'h4FFF
`define SECTOR_ADDR_BITS   8
// Timing counts in core clock cycles at 10 MHz: 10 us, 20 us, 400 us and the verify span.
`define INIT_CYCLES        16'h0064
`define PROG_CYCLES        16'h00C8
`define ERASE_CYCLES       16'h0FA0
`define VERIFY_CYCLES      16'h0004
`endif

// *** rtl/param_buffer.v ***
// Indexed command parameter buffer with six 16-bit slots.
`timescale 1ns/1ps
module param_buffer (
   input  wire        core_clk_i,
   input  wire        resetn_i,
   input  wire        wr_en_i,
   input  wire [2:0]  wr_idx_i,
   input  wire [15:0] wr_data_i,
   input  wire [2:0]  rd_idx_i,
   output wire [15:0] rd_data_o
);
   reg [15:0] slot_r [0:5];
   genvar     g;

   generate
      for (g = 0; g < 6; g = g + 1) begin : g_slot
         always @(posedge core_clk_i or negedge resetn_i) begin
            if (!resetn_i) begin
               slot_r[g] <= 16'h0000;
            end else if (wr_en_i && (wr_idx_i == g)) begin
               slot_r[g] <= wr_data_i;
            end
         end
      end
   endgenerate

   // Slots six and seven do not exist and read as zero.
   assign rd_data_o = (rd_idx_i < 3'h6) ? slot_r[rd_idx_i] : 16'h0000;
endmodule // param_buffer

// *** tb/data_flash_program_erase_seq_chk.sv ***
// Port-level assertions for the data-flash program and erase sequencer.
`timescale 1ns/1ps
module data_flash_program_erase_seq_chk (
   input wire core_clk_i,
   input wire resetn_i,
   input wire cmd_complete_clr_i,
   input wire cmd_permitted_i,
   input wire area_protected_i,
   input wire cmd_complete_irq_en_i,
   input wire double_fault_irq_en_i,
   input wire single_fault_irq_en_i,
   input wire array_read_i,
   input wire ecc_double_i,
   input wire stop_req_i,
   input wire array_prog_o,
   input wire array_erase_o,
   input wire cmd_complete_flag_o,
   input wire access_error_flag_o,
   input wire verify_error_flag_o,
   input wire verify_uncorrectable_flag_o,
   input wire double_fault_flag_o,
   input wire single_fault_flag_o,
   input wire cmd_irq_o,
   input wire err_irq_o,
   input wire stop_ack_o
);
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!resetn_i);
   wire launch = cmd_complete_flag_o && cmd_complete_clr_i;
   wire no_op  = !array_prog_o && !array_erase_o;
   chk_cmd_irq_gate: assert property (
      cmd_irq_o == (cmd_complete_flag_o && cmd_complete_irq_en_i)) else $error("cmd irq");
   chk_err_irq_gate: assert property (
      err_irq_o == ((double_fault_flag_o && double_fault_irq_en_i) ||
                    (single_fault_flag_o && single_fault_irq_en_i))) else $error("err irq");
   chk_stop_ack_gate: assert property (
      stop_ack_o == (stop_req_i && cmd_complete_flag_o)) else $error("stop ack");
   chk_launch_clears_flag: assert property (
      launch |=> !cmd_complete_flag_o) else $error("flag not cleared");
   chk_mode_refused: assert property (launch && !cmd_permitted_i |=>
      no_op [*3] ##[0:2] (cmd_complete_flag_o && access_error_flag_o)) else $error("mode");
   chk_protect_no_op: assert property (launch && area_protected_i |=>
      no_op [*3] ##[0:2] cmd_complete_flag_o) else $error("protected area touched");
   chk_busy_on_pulse: assert property (
      !no_op |-> !cmd_complete_flag_o) else $error("pulse while idle");
   chk_verify_pair: assert property (
      verify_uncorrectable_flag_o |-> verify_error_flag_o) else $error("verify pair");
   chk_double_capture: assert property (
      array_read_i && ecc_double_i |=> double_fault_flag_o) else $error("double fault lost");
   cover property (array_prog_o);
   cover property (array_erase_o);
   cover property (stop_ack_o);
   cover property (err_irq_o);
endmodule // data_flash_program_erase_seq_chk

// *** tb/data_flash_program_erase_seq_tb_top.sv ***
// Self-checking bench for the data-flash program and erase sequencer.
`timescale 1ns/1ps
module data_flash_program_erase_seq_tb_top;
   reg         core_clk_i, resetn_i, param_slot_index_wr_i, command_param_buffer_wr_i;
   reg  [2:0]  param_slot_index_i;
   reg  [15:0] command_param_buffer_data_i;
   reg         cmd_complete_clr_i, access_error_clr_i, protect_violation_clr_i;
   reg         double_fault_clr_i, single_fault_clr_i, cmd_complete_irq_en_i;
   reg         double_fault_irq_en_i, single_fault_irq_en_i, cmd_permitted_i;
   reg         area_protected_i, array_read_i, ecc_single_i, ecc_double_i, stop_req_i;
   wire [2:0]  param_slot_index_o;
   wire [15:0] command_param_buffer_o, array_addr_o, array_wdata_o;
   wire        array_prog_o, array_erase_o, cmd_complete_flag_o, access_error_flag_o;
   wire        protect_violation_flag_o, verify_error_flag_o, verify_uncorrectable_flag_o;
   wire        double_fault_flag_o, single_fault_flag_o, cmd_irq_o, err_irq_o, stop_ack_o;
   integer     failures, num_checks, n_prog, n_erase, i;
   reg  [15:0] first_addr, last_data, k;
   reg  [26:0] r;

   data_flash_program_erase_seq data_flash_program_erase_seq_inst (.*);

   initial begin
      core_clk_i = 1'b0;
      forever #50 core_clk_i = ~core_clk_i;
   end

   // Pulses are counted from the pre-edge values, so no race with the design.
   always @(posedge core_clk_i) begin
      if (array_prog_o === 1'b1) begin
         if (n_prog == 0) first_addr = array_addr_o;
         last_data = array_wdata_o;
         n_prog = n_prog + 1;
      end
      if (array_erase_o === 1'b1) n_erase = n_erase + 1;
   end

   task chk(input [15:0] got, input [15:0] exp);
      begin
         num_checks = num_checks + 1;
         if (got !== exp) begin
            failures = failures + 1;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
         end
      end
   endtask

   task wr(input [2:0] idx, input [15:0] d);
      begin
         @(posedge core_clk_i);
         param_slot_index_wr_i <= 1'b1;
         param_slot_index_i <= idx;
         @(posedge core_clk_i);
         param_slot_index_wr_i <= 1'b0;
         command_param_buffer_wr_i <= 1'b1;
         command_param_buffer_data_i <= d;
         @(posedge core_clk_i);
         command_param_buffer_wr_i <= 1'b0;
      end
   endtask

   task launch;
      begin
         n_prog = 0;
         n_erase = 0;
         @(posedge core_clk_i);
         cmd_complete_clr_i <= 1'b1;
         @(posedge core_clk_i);
         cmd_complete_clr_i <= 1'b0;
         @(posedge core_clk_i);
         chk(cmd_complete_flag_o, 16'h0);
         chk(stop_ack_o, 16'h0);
      end
   endtask

   // Loads the slots in order, leaves the index at the last slot and waits for completion.
   task run(input [7:0] code, input [15:0] addr, input [2:0] idx);
      begin
         wr(3'h0, {code, 8'h00});
         wr(3'h1, addr);
         for (i = 2; i <= idx; i = i + 1) wr(i[2:0], 16'hA000 + i[15:0]);
         if (idx == 3'h0) wr(3'h0, {code, 8'h00});
         launch;
         i = 0;
         while (cmd_complete_flag_o !== 1'b1 && i < 9000) begin
            @(posedge core_clk_i);
            i = i + 1;
         end
         chk(cmd_complete_flag_o, 16'h1);
      end
   endtask

   task expect_res(input acc, input pv, input [15:0] np, input [15:0] ne);
      begin
         chk(access_error_flag_o, acc);
         chk(protect_violation_flag_o, pv);
         chk(n_prog[15:0], np);
         chk(n_erase[15:0], ne);
         @(posedge core_clk_i);
         access_error_clr_i <= 1'b1;
         protect_violation_clr_i <= 1'b1;
         @(posedge core_clk_i);
         access_error_clr_i <= 1'b0;
         protect_violation_clr_i <= 1'b0;
      end
   endtask

   task report_and_stop;
      begin
         $display("checks=%0d failures=%0d", num_checks, failures);
         if (failures == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
         end else begin
            $display("Run complete: FAIL");
         end
         $finish;
      end
   endtask

   function [26:0] row(input [15:0] n);
      case (n)
         0: row = {8'h11, 16'h4000, 3'h1};
         1: row = {8'h11, 16'h4000, 3'h6};
         2: row = {8'h11, 16'h4001, 3'h2};
         3: row = {8'h11, 16'h2000, 3'h2};
         4: row = {8'h11, 16'h4FFE, 3'h3};
         5: row = {8'h12, 16'h4100, 3'h0};
         6: row = {8'h12, 16'h4101, 3'h1};
         7: row = {8'h33, 16'h4000, 3'h1};
         default: row = {8'h11, 16'h4000, 3'h2};
      endcase
   endfunction

   initial begin
      {resetn_i, param_slot_index_wr_i, command_param_buffer_wr_i, param_slot_index_i} = 0;
      {command_param_buffer_data_i, cmd_complete_clr_i, access_error_clr_i} = 0;
      {protect_violation_clr_i, double_fault_clr_i, single_fault_clr_i} = 0;
      {cmd_complete_irq_en_i, double_fault_irq_en_i, single_fault_irq_en_i} = 0;
      {area_protected_i, array_read_i, ecc_single_i, ecc_double_i, stop_req_i} = 0;
      cmd_permitted_i = 1'b1;
      {failures, num_checks, n_prog, n_erase} = 0;
      repeat (6) @(posedge core_clk_i);
      resetn_i <= 1'b1;
      wr(3'h3, 16'h1234);
      repeat (40) @(posedge core_clk_i);
      chk(param_slot_index_o, 16'h0);
      chk(cmd_complete_flag_o, 16'h0);
      repeat (80) @(posedge core_clk_i);
      chk(cmd_complete_flag_o, 16'h1);
      wr(3'h3, 16'h1234);
      @(posedge core_clk_i);
      chk(param_slot_index_o, 16'h3);
      chk(command_param_buffer_o, 16'h1234);
      $display("test init done");
      cmd_complete_irq_en_i <= 1'b1;
      for (k = 2; k <= 5; k = k + 1) begin
         run(8'h11, 16'h4100 + 16'h10 * k, k[2:0]);
         expect_res(1'b0, 1'b0, k - 16'h1, 16'h0);
         chk(first_addr, 16'h4100 + 16'h10 * k);
         chk(last_data, 16'hA000 + k);
         chk(cmd_irq_o, 16'h1);
      end
      $display("test program words done");
      for (k = 0; k < 10; k = k + 1) begin
         r = row(k);
         cmd_permitted_i <= (k != 8);
         area_protected_i <= (k == 9);
         run(r[26:19], r[18:3], r[2:0]);
         expect_res(k != 9, k == 9, 16'h0, 16'h0);
      end
      area_protected_i <= 1'b0;
      $display("test refusals done");
      double_fault_irq_en_i <= 1'b1;
      array_read_i <= 1'b1;
      ecc_double_i <= 1'b1;
      run(8'h11, 16'h4800, 3'h2);
      chk(verify_error_flag_o, 16'h1);
      chk(verify_uncorrectable_flag_o, 16'h1);
      chk(double_fault_flag_o, 16'h1);
      chk(err_irq_o, 16'h1);
      ecc_double_i <= 1'b0;
      ecc_single_i <= 1'b1;
      double_fault_clr_i <= 1'b1;
      double_fault_irq_en_i <= 1'b0;
      single_fault_irq_en_i <= 1'b1;
      @(posedge core_clk_i);
      double_fault_clr_i <= 1'b0;
      run(8'h11, 16'h4810, 3'h2);
      chk(verify_error_flag_o, 16'h1);
      chk(verify_uncorrectable_flag_o, 16'h0);
      chk({double_fault_flag_o, single_fault_flag_o, err_irq_o}, 16'h3);
      array_read_i <= 1'b0;
      ecc_single_i <= 1'b0;
      $display("test verify and faults done");
      stop_req_i <= 1'b1;
      run(8'h12, 16'h4122, 3'h1);
      expect_res(1'b0, 1'b0, 16'h0, 16'h1);
      chk(verify_error_flag_o, 16'h0);
      chk(stop_ack_o, 16'h1);
      $display("test erase and stop done");
      wr(3'h0, 16'h1200);
      wr(3'h1, 16'h4200);
      launch;
      repeat (50) @(posedge core_clk_i);
      resetn_i <= 1'b0;
      repeat (2) @(posedge core_clk_i);
      chk({cmd_complete_flag_o, array_erase_o}, 16'h0);
      resetn_i <= 1'b1;
      repeat (150) @(posedge core_clk_i);
      chk(cmd_complete_flag_o, 16'h1);
      $display("test reset abort done");
      report_and_stop;
   end

   initial begin
      #3000000;
      failures = failures + 1;
      report_and_stop;
   end
endmodule // data_flash_program_erase_seq_tb_top

bind data_flash_program_erase_seq data_flash_program_erase_seq_chk chk_inst (.*);
